// *** awr_regs.svh ***
`ifndef AWR_REGS_SVH
`define AWR_REGS_SVH
`define AWR_ADDR_W 16
`define AWR_DELAY_W 10
`define AWR_DELAY_MAX 10'h3e7
`define AWR_DELAY_RST 10'h000
`define AWR_PRESET_RST 16'h0000
`endif

// *** awr_pkg.sv ***
`default_nettype none
package awr_pkg;
    typedef enum logic [1:0]
    {
        AWR_MATCH_PULSE_OUT_OFF = 2'b00,
        AWR_MATCH_PULSE_OUT_SYNC = 2'b01,
        AWR_MATCH_PULSE_OUT_UNCLOCKED = 2'b10
    } awr_match_pulse_out_mode_t;
    typedef enum logic [1:0]
    {
        AWR_QUAL_ZERO = 2'b00,
        AWR_QUAL_ONE = 2'b01,
        AWR_QUAL_ANY = 2'b10
    } awr_qual_sel_t;
    typedef enum logic
    {
        AWR_DLY_CLOCKS = 1'b0,
        AWR_DLY_MATCHES = 1'b1
    } awr_dly_mode_t;
    typedef struct packed
    {
        awr_match_pulse_out_mode_t match_pulse_out_mode;
        awr_qual_sel_t qual_sel;
        awr_dly_mode_t dly_mode;
        logic clk_edge_neg;
        logic clk_qual_en;
        logic clk_qual_level;
        logic [9:0] delay_count;
        logic [15:0] preset_addr;
    } awr_cfg_t;
endpackage
`default_nettype wire

// *** awr_word_match.sv ***
`timescale 1ns/100ps
`default_nettype none
module awr_word_match
#(
    parameter int ADDR_W = 16
)
(
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [ADDR_W-1:0] preset,
    input wire logic qual_in,
    input wire awr_pkg::awr_qual_sel_t qual_sel,
    output logic match
);
    import awr_pkg::*;
    logic [ADDR_W-1:0] bit_eq;
    logic qual_ok;
    genvar i;
    // ********************
    // Per-bit comparison
    // ********************
    generate
        for (i = 0; i < ADDR_W; i++)
        begin : g_bit
            assign bit_eq[i] = ~(addr_in[i] ^ preset[i]);
        end
    endgenerate
    always_comb
    begin
        unique case (qual_sel)
            AWR_QUAL_ZERO: qual_ok = ~qual_in;
            AWR_QUAL_ONE: qual_ok = qual_in;
            AWR_QUAL_ANY: qual_ok = 1'b1;
            default: qual_ok = 1'b0;
        endcase
    end
    assign match = (&bit_eq) & qual_ok;
endmodule
`default_nettype wire

// *** awr_recognizer.sv ***
`include "awr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module awr_recognizer
#(
    parameter int ADDR_W = `AWR_ADDR_W,
    parameter int DELAY_W = `AWR_DELAY_W
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire awr_pkg::awr_cfg_t cfg,
    input wire logic rearm,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic qual_in,
    input wire logic probe_clk,
    input wire logic clk_qual_in,
    output logic match_pulse_out,
    output logic armed_led
);
    import awr_pkg::*;
    typedef enum logic [1:0]
    {
        AWR_ST_IDLE = 2'b00,
        AWR_ST_WAIT = 2'b01,
        AWR_ST_FIRE = 2'b10
    } awr_state_t;
    logic [ADDR_W-1:0] preset;
    logic [ADDR_W-1:0] next_preset;
    logic armed;
    logic next_armed;
    logic probe_clk_q;
    logic next_probe_clk_q;
    logic sync_pulse;
    logic next_sync_pulse;
    awr_state_t state;
    awr_state_t next_state;
    logic [DELAY_W-1:0] cnt;
    logic [DELAY_W-1:0] next_cnt;
    logic raw_unclk;
    logic raw_sync;
    logic sample_edge;
    logic fire;
    logic [DELAY_W-1:0] dly;
    // ****************************
    // Comparators
    // ****************************
    awr_word_match #(.ADDR_W(ADDR_W)) awr_word_match_inst
    (
        .addr_in(addr_in),
        .preset(preset),
        .qual_in(qual_in),
        .qual_sel(cfg.qual_sel),
        .match(raw_unclk)
    );
    assign raw_sync = raw_unclk;
    assign dly = (cfg.delay_count > `AWR_DELAY_MAX) ? `AWR_DELAY_MAX
        : cfg.delay_count;
    // ****************************
    // Sampling edge of probe clock
    // ****************************
    always_comb
    begin
        next_probe_clk_q = probe_clk;
        sample_edge = (cfg.clk_edge_neg ? (probe_clk_q & ~probe_clk)
            : (~probe_clk_q & probe_clk))
            & (~cfg.clk_qual_en | (clk_qual_in == cfg.clk_qual_level));
    end
    // ****************************
    // Arming and delay sequencing
    // ****************************
    always_comb
    begin
        next_preset = preset;
        next_armed = armed;
        next_state = state;
        next_cnt = cnt;
        next_sync_pulse = 1'b0;
        fire = 1'b0;
        if (rearm)
        begin
            next_preset = cfg.preset_addr;
            next_armed = 1'b1;
            next_state = AWR_ST_IDLE;
            next_cnt = '0;
        end
        else if (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_SYNC && sample_edge)
        begin
            unique case (state)
                AWR_ST_IDLE:
                begin
                    if (raw_sync)
                    begin
                        if (dly == '0)
                            fire = 1'b1;
                        else
                        begin
                            next_state = AWR_ST_WAIT;
                            next_cnt = dly - 1'b1;
                            if (cfg.dly_mode == AWR_DLY_CLOCKS && dly == 1)
                                fire = 1'b0;
                        end
                    end
                end
                AWR_ST_WAIT:
                begin
                    if (cfg.dly_mode == AWR_DLY_CLOCKS || raw_sync)
                    begin
                        if (cnt == '0)
                        begin
                            fire = 1'b1;
                            next_state = AWR_ST_IDLE;
                        end
                        else
                            next_cnt = cnt - 1'b1;
                    end
                end
                AWR_ST_FIRE: next_state = AWR_ST_IDLE;
                default: next_state = AWR_ST_IDLE;
            endcase
        end
        if (fire)
        begin
            next_sync_pulse = 1'b1;
            next_armed = 1'b0;
        end
        else if (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_UNCLOCKED && raw_unclk && !rearm)
            next_armed = 1'b0;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preset <= `AWR_PRESET_RST;
            armed <= 1'b0;
            probe_clk_q <= 1'b0;
            sync_pulse <= 1'b0;
            state <= AWR_ST_IDLE;
            cnt <= `AWR_DELAY_RST;
        end
        else if (clk_en)
        begin
            preset <= next_preset;
            armed <= next_armed;
            probe_clk_q <= next_probe_clk_q;
            sync_pulse <= next_sync_pulse;
            state <= next_state;
            cnt <= next_cnt;
        end
    end
    // ****************************
    // Output selection
    // ****************************
    always_comb
    begin
        unique case (cfg.match_pulse_out_mode)
            AWR_MATCH_PULSE_OUT_UNCLOCKED:
                match_pulse_out = raw_unclk;
            AWR_MATCH_PULSE_OUT_SYNC: match_pulse_out = sync_pulse;
            default: match_pulse_out = 1'b0;
        endcase
    end
    assign armed_led = armed;
    // ****************************
    // Assertions
    // ****************************
    a_unclk_follows: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_UNCLOCKED) |->
        match_pulse_out == ((addr_in == preset)
        && (cfg.qual_sel == AWR_QUAL_ANY
        || (cfg.qual_sel == AWR_QUAL_ONE && qual_in)
        || (cfg.qual_sel == AWR_QUAL_ZERO && !qual_in))))
        else $error("unclocked output differs from compare");
    a_rearm_loads: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (rearm && clk_en) |=> (preset == $past(cfg.preset_addr) && armed))
        else $error("rearm did not load preset");
    a_fire_disarms: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_SYNC && sync_pulse) |-> !armed)
        else $error("armed after trigger");
    a_zero_delay: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !rearm && cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_SYNC && sample_edge
        && state == AWR_ST_IDLE && raw_sync && dly == '0) |=> sync_pulse)
        else $error("zero delay pulse missing");
    a_pulse_single: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (sync_pulse && clk_en) |=> !sync_pulse)
        else $error("trigger pulse longer than one cycle");
    a_mismatch_low: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_UNCLOCKED && addr_in != preset)
        |-> !match_pulse_out)
        else $error("output high on mismatch");
    a_wait_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !rearm && state == AWR_ST_WAIT && !sample_edge)
        |=> state == AWR_ST_WAIT && cnt == $past(cnt))
        else $error("delay moved without edge");
    a_off_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_OFF) |-> !match_pulse_out)
        else $error("output in off mode");
    a_freeze_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> $stable(state) && $stable(cnt) && $stable(armed)
        && $stable(sync_pulse) && $stable(preset))
        else $error("state moved while clock enable low");
    c_unclk_hit: cover property (@(posedge ref_clk) disable iff (!rst_n)
        cfg.match_pulse_out_mode == AWR_MATCH_PULSE_OUT_UNCLOCKED && match_pulse_out);
    c_sync_delay: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state == AWR_ST_WAIT ##1 sync_pulse);
    c_rearm: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rearm ##1 armed ##[1:50] !armed);
    c_freeze_resume: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !clk_en ##1 clk_en ##[1:4] sync_pulse);
endmodule
`default_nettype wire

// *** awr_cut_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Circuit-under-test bus model
// ****************************************
module awr_cut_model
(
    input wire logic ref_clk,
    input wire logic run,
    input wire logic valid,
    input wire logic lvl,
    input wire logic [15:0] word,
    output logic [15:0] addr_bus,
    output logic strobe,
    output var logic bus_clk = 1'b0
);
    // Bus clock stands still while run is low
    always @(posedge ref_clk)
    begin
        if (run)
        begin
            bus_clk <= ~bus_clk;
        end
    end
    // Invalid bus shows the inverse word; qualifier strobes valid words
    assign addr_bus = valid ? word : ~word;
    assign strobe = valid & lvl;
endmodule
`default_nettype wire

// *** awr_recognizer_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module awr_recognizer_test;
    import awr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rearm = 1'b0;
    logic clk_en = 1'b1;
    logic clk_qual_in = 1'b0;
    logic run = 1'b0;
    logic valid = 1'b0;
    logic lvl = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [15:0] addr_in;
    logic qual_in;
    logic probe_clk;
    logic match_pulse_out;
    logic armed_led;
    awr_cfg_t cfg = '0;
    int err_total = 0;
    int check_count = 0;
    int t0;
    int t1;
    int t2;
    always #25 ref_clk = ~ref_clk;
    awr_recognizer awr_recognizer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .cfg(cfg), .rearm(rearm), .addr_in(addr_in),
        .qual_in(qual_in), .probe_clk(probe_clk),
        .clk_qual_in(clk_qual_in),
        .match_pulse_out(match_pulse_out), .armed_led(armed_led));
    awr_cut_model awr_cut_model_inst (.ref_clk(ref_clk), .run(run),
        .valid(valid), .lvl(lvl), .word(word), .addr_bus(addr_in),
        .strobe(qual_in), .bus_clk(probe_clk));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task drive(input logic v, input logic q, input logic [15:0] w);
        @(negedge ref_clk);
        valid = v;
        lvl = q;
        word = w;
        #1;
    endtask
    task do_rearm;
        @(negedge ref_clk);
        rearm = 1'b1;
        @(negedge ref_clk);
        rearm = 1'b0;
    endtask
    task measure(input int n, input int lim, output int cyc);
        cfg.delay_count = 10'(n);
        cyc = -1;
        do @(negedge ref_clk); while (probe_clk !== 1'b0);
        rearm = 1'b1;
        @(negedge ref_clk);
        rearm = 1'b0;
        for (int i = 0; i < lim && cyc < 0; i++)
        begin
            @(negedge ref_clk);
            if (match_pulse_out === 1'b1)
            begin
                cyc = i;
            end
        end
        @(negedge ref_clk);
        chk(match_pulse_out, 1'b0);
        chk(armed_led, cyc < 0);
    endtask
    task print_verdict;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        #1000000;
        err_total++;
        print_verdict;
    end
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        cfg.match_pulse_out_mode = AWR_MATCH_PULSE_OUT_UNCLOCKED;
        cfg.preset_addr = 16'ha5c3;
        drive(1'b0, 1'b0, 16'ha5c3);
        do_rearm;
        chk(armed_led, 1'b1);
        for (int s = 0; s < 3; s++)
        begin
            for (int q = 0; q < 2; q++)
            begin
                cfg.qual_sel = awr_qual_sel_t'(2'(s));
                cfg.delay_count = 10'(s * 300 + q);
                cfg.clk_edge_neg = q[0];
                cfg.dly_mode = awr_dly_mode_t'(s[0]);
                drive(1'b1, q[0], 16'ha5c3);
                chk(match_pulse_out, s == 2 || s == q);
            end
        end
        chk(armed_led, 1'b0);
        for (int b = 0; b < 16; b++)
        begin
            drive(1'b1, 1'b0, 16'ha5c3 ^ (16'h0001 << b));
            chk(match_pulse_out, 1'b0);
        end
        cfg.preset_addr = 16'h3c5a;
        drive(1'b1, 1'b0, 16'h3c5a);
        chk(match_pulse_out, 1'b0);
        drive(1'b1, 1'b0, 16'ha5c3);
        chk(match_pulse_out, 1'b1);
        do_rearm;
        drive(1'b0, 1'b0, 16'h3c5a);
        chk(match_pulse_out, 1'b0);
        #5 valid = 1'b1;
        #1 chk(match_pulse_out, 1'b1);
        #3 valid = 1'b0;
        #1 chk(match_pulse_out, 1'b0);
        cfg.match_pulse_out_mode = AWR_MATCH_PULSE_OUT_SYNC;
        cfg.clk_edge_neg = 1'b0;
        run = 1'b1;
        measure(0, 40, t0);
        chk(t0, -1);
        drive(1'b1, 1'b0, 16'h3c5a);
        for (int m = 0; m < 2; m++)
        begin
            cfg.dly_mode = awr_dly_mode_t'(m[0]);
            measure(0, 40, t0);
            for (int n = 1; n < 4; n++)
            begin
                measure(n, 40, t1);
                chk(t1 - t0, 2 * n);
            end
        end
        cfg.dly_mode = AWR_DLY_CLOCKS;
        measure(999, 2100, t1);
        chk(t1 - t0, 1998);
        measure(1023, 2100, t2);
        chk(t2, t1);
        cfg.clk_edge_neg = 1'b1;
        measure(0, 40, t2);
        chk(t2, 1);
        cfg.clk_edge_neg = 1'b0;
        cfg.clk_qual_en = 1'b1;
        cfg.clk_qual_level = 1'b1;
        measure(0, 40, t2);
        chk(t2, -1);
        clk_qual_in = 1'b1;
        measure(0, 40, t2);
        chk(t2, 0);
        cfg.clk_qual_en = 1'b0;
        // Match count skips edges without a match
        cfg.dly_mode = AWR_DLY_MATCHES;
        cfg.delay_count = 10'h001;
        do @(negedge ref_clk); while (probe_clk !== 1'b0);
        rearm = 1'b1;
        @(negedge ref_clk);
        rearm = 1'b0;
        @(negedge ref_clk);
        valid = 1'b0;
        t1 = 0;
        repeat (4)
        begin
            @(negedge ref_clk);
            if (match_pulse_out !== 1'b0)
            begin
                t1++;
            end
        end
        valid = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(t1, 0);
        chk(match_pulse_out, 1'b1);
        // Clock enable low freezes the recognizer
        cfg.dly_mode = AWR_DLY_CLOCKS;
        cfg.delay_count = 10'h000;
        do @(negedge ref_clk); while (probe_clk !== 1'b0);
        rearm = 1'b1;
        @(negedge ref_clk);
        rearm = 1'b0;
        clk_en = 1'b0;
        t1 = 0;
        repeat (10)
        begin
            @(negedge ref_clk);
            if (match_pulse_out !== 1'b0)
            begin
                t1++;
            end
        end
        chk(t1, 0);
        chk(armed_led, 1'b1);
        clk_en = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(armed_led, 1'b0);
        // Off mode and a reset in mid-run
        cfg.match_pulse_out_mode = AWR_MATCH_PULSE_OUT_OFF;
        do_rearm;
        repeat (4) @(negedge ref_clk);
        chk(match_pulse_out, 1'b0);
        chk(armed_led, 1'b1);
        rst_n = 1'b0;
        @(negedge ref_clk);
        chk(armed_led, 1'b0);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(armed_led, 1'b0);
        chk(match_pulse_out, 1'b0);
        run = 1'b0;
        print_verdict;
    end
endmodule
`default_nettype wire
